// ---- rtl/cpi_pkg.sv ----
// package: register map, field positions, reset values and states of the interrupt-source block
package cpi_pkg;
   // register offsets, byte addresses on the plain register port
   localparam logic [3:0] ADDR_IRQ_CTRL  = 4'h0;
   localparam logic [3:0] ADDR_RATE      = 4'h1;
   localparam logic [3:0] ADDR_LV_CTRL   = 4'h2;
   localparam logic [3:0] ADDR_AP_CTRL   = 4'h3;
   localparam logic [3:0] ADDR_CLK_CTRL  = 4'h4;
   localparam logic [3:0] ADDR_STATUS    = 4'h5;
   localparam logic [3:0] ADDR_FLAGS     = 4'h6;
   localparam logic [3:0] ADDR_MASK      = 4'h7;
   localparam logic [3:0] ADDR_LV_FLAG   = 4'h8;
   localparam logic [3:0] ADDR_AP_FLAG   = 4'h9;
   // field positions
   localparam int FLD_TIMEOUT = 0;
   localparam int FLD_LOCK    = 1;
   localparam int FLD_OSC     = 2;
   localparam int FLD_LV      = 3;
   localparam int FLD_AP      = 4;
   localparam int NUM_SRC     = 5;
   localparam int CLK_SEL_BIT = 0;
   localparam int PSEUDO_STOP_SELECT_BIT    = 1;
   localparam int OSCRUN_BIT  = 2;
   localparam int OSCEN_BIT   = 3;
   localparam int STS_UP_BIT  = 0;
   localparam int STS_LOCK_BIT = 1;
   // reset values
   localparam logic [7:0] RATE_RESET = 8'h00;
   localparam logic [4:0] MASK_RESET = 5'h00;
   localparam logic [2:0] IE_RESET   = 3'h0;
   // timer width and the states of the timer
   localparam int TMR_W = 16;
   typedef enum logic [1:0]
   {
      TMR_RUN  = 2'b00,
      TMR_HALT = 2'b01,
      TMR_OFF  = 2'b10
   } cpi_tmr_type;
endpackage

// ---- rtl/cpi_if.sv ----
// interface: timer controls and expiry between main block and timeout counter
`timescale 1ns/1ps
interface cpi_tmr_if;
   logic       tick;
   logic       restart;
   logic [7:0] rate;
   logic       expire;
   modport ctl (output tick, output restart, output rate, input expire);
   modport tmr (input tick, input restart, input rate, output expire);
endinterface

// ---- rtl/cpi_timeout_timer.sv ----
// periodic timeout counter: counts selected clock ticks, expires at rate, reloads
`timescale 1ns/1ps
module cpi_timeout_timer
(
   input wire logic sys_clk,
   input wire logic rst_b,
   cpi_tmr_if.tmr   tmr
);
   logic [cpi_pkg::TMR_W-1:0] cnt_q;
   logic [cpi_pkg::TMR_W-1:0] cnt_d;
   logic [cpi_pkg::TMR_W-1:0] limit;
   logic                      hit;
   logic                      expire_q;

   // period is (rate+1)*16 ticks; zero rate still gives a nonzero period
   assign limit = {4'h0, tmr.rate, 4'hf};
   assign hit   = tmr.tick && (cnt_q == limit);
   // restart wins over counting; hit reloads at once so periods abut [R5] [R6]
   assign cnt_d = tmr.restart ? '0 : hit ? '0 : tmr.tick ? cnt_q + 1'b1 : cnt_q;
   assign tmr.expire = expire_q;

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         cnt_q    <= '0;
         expire_q <= 1'b0;
      end
      else
      begin
         cnt_q    <= cnt_d;
         expire_q <= hit && !tmr.restart;
      end
   end
endmodule // cpi_timeout_timer

// ---- rtl/cpi_irq_sources.sv ----
// interrupt sources of the clock and power unit: timeout, lock, oscillator, low voltage, periodic
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////////////////////////
// Contract
// R1 - five requests, local enables, CPU masks globally
// R2 - timer clocked by RC or oscillator
// R3 - stop halts timer unless pseudo-stop oscillator run
// R4 - enabled timer requests at programmed rate
// R5 - expiry sets flag, next period starts
// R6 - rate write restarts the period
// R7 - lock change either way raises flag
// R8 - cleared lock enable suppresses request
// R9 - lock flag set by change, write-one clears
// R10 - oscillator disabled keeps up status zero
// R11 - up status set only after lock
// R12 - up status change sets oscillator flag
// R13 - stop or disable changes count too
// R14 - request high while flag and enable
// R15 - timeout and oscillator flags write-one clear
module cpi_irq_sources
(
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   input  wire logic [3:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWrStb,
   input  wire logic       regRdStb,
   output logic      [7:0] regRdData,
   input  wire logic       internal_rc_clock,
   input  wire logic       crystal_osc_clock,
   input  wire logic       pllLock,
   input  wire logic       oscStable,
   input  wire logic       stopMode,
   input  wire logic       lowVoltage,
   input  wire logic       apiEvent,
   output logic      [4:0] irqReq,
   output logic            irqOut
);
   //////////////////////////////////////////////////////////////////////////////////////////////
   logic [2:0] irqCtrl_q;
   logic [7:0] rate_q;
   logic       low_voltage_irq_enable_q;
   logic       autonomous_periodic_irq_enable_q;
   logic [3:0] clkCtrl_q;
   logic [4:0] flags_q;
   logic [4:0] flags_d;
   logic [4:0] mask_q;
   logic       lock_q;
   logic       lockSeen_q;
   logic       oscUp_q;
   logic       oscUp_d;
   logic       lv_q;
   logic       rcPrev_q;
   logic       xoPrev_q;
   logic [7:0] rdData_q;
   logic [4:0] irqReq_q;
   logic       irqOut_q;
   logic [4:0] enables;
   logic [4:0] events;
   logic [4:0] clrMask;
   logic       wrRate;
   logic       wrFlags;
   logic       selOsc;
   logic       runInStop;
   logic       srcTick;
   logic [7:0] rdMux;
   cpi_pkg::cpi_tmr_type tmrState;

   cpi_tmr_if tmrBus ();

   cpi_timeout_timer timer
   (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .tmr     (tmrBus)
   );

   //////////////////////////////////////////////////////////////////////////////////////////////
   // timer clock choice and stop behaviour
   assign selOsc    = clkCtrl_q[cpi_pkg::CLK_SEL_BIT];
   // clock inputs sampled as synchronous levels; a rising edge is one tick [R2]
   assign srcTick   = selOsc ? (crystal_osc_clock && !xoPrev_q)
                             : (internal_rc_clock && !rcPrev_q);
   assign runInStop = clkCtrl_q[cpi_pkg::PSEUDO_STOP_SELECT_BIT] && selOsc
                      && clkCtrl_q[cpi_pkg::OSCRUN_BIT];
   assign tmrState  = (stopMode && !runInStop) ? cpi_pkg::TMR_HALT : cpi_pkg::TMR_RUN; // [R3]
   assign wrRate    = regWrStb && (regAddr == cpi_pkg::ADDR_RATE);
   assign tmrBus.tick    = srcTick && (tmrState == cpi_pkg::TMR_RUN);
   assign tmrBus.restart = wrRate; // [R6]
   assign tmrBus.rate    = rate_q;

   //////////////////////////////////////////////////////////////////////////////////////////////
   // oscillator up status: zero while disabled, and only once lock has been seen [R10] [R11]
   // full stop drops it too, so entering stop counts as a status change [R13]
   assign oscUp_d = clkCtrl_q[cpi_pkg::OSCEN_BIT] && oscStable && lockSeen_q
                    && !(stopMode && !runInStop);

   // events and flags; set wins over a same-cycle clear
   assign events[cpi_pkg::FLD_TIMEOUT] = tmrBus.expire;            // [R5]
   assign events[cpi_pkg::FLD_LOCK]    = pllLock != lock_q;        // [R7] [R9]
   assign events[cpi_pkg::FLD_OSC]     = oscUp_d != oscUp_q;       // [R12] [R13]
   assign events[cpi_pkg::FLD_LV]      = lowVoltage && !lv_q;
   assign events[cpi_pkg::FLD_AP]      = apiEvent;
   assign wrFlags = regWrStb && (regAddr == cpi_pkg::ADDR_FLAGS);
   assign clrMask = wrFlags ? regWrData[4:0] : 5'h00;               // [R9] [R15]
   assign flags_d = (flags_q & ~clrMask) | events;

   assign enables = {autonomous_periodic_irq_enable_q, low_voltage_irq_enable_q, irqCtrl_q};                    // [R1]

   //////////////////////////////////////////////////////////////////////////////////////////////
   // register read mux, unmapped addresses read zero
   assign rdMux = (regAddr == cpi_pkg::ADDR_IRQ_CTRL) ? {5'h00, irqCtrl_q} :
                  (regAddr == cpi_pkg::ADDR_RATE)     ? rate_q :
                  (regAddr == cpi_pkg::ADDR_LV_CTRL)  ? {7'h00, low_voltage_irq_enable_q} :
                  (regAddr == cpi_pkg::ADDR_AP_CTRL)  ? {7'h00, autonomous_periodic_irq_enable_q} :
                  (regAddr == cpi_pkg::ADDR_CLK_CTRL) ? {4'h0, clkCtrl_q} :
                  (regAddr == cpi_pkg::ADDR_STATUS)   ? {6'h00, lock_q, oscUp_q} :
                  (regAddr == cpi_pkg::ADDR_FLAGS)    ? {3'h0, flags_q} :
                  (regAddr == cpi_pkg::ADDR_MASK)     ? {3'h0, mask_q} : 8'h00;

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         irqCtrl_q <= cpi_pkg::IE_RESET;
         rate_q    <= cpi_pkg::RATE_RESET;
         low_voltage_irq_enable_q    <= 1'b0;
         autonomous_periodic_irq_enable_q    <= 1'b0;
         clkCtrl_q <= 4'h0;
         mask_q    <= cpi_pkg::MASK_RESET;
      end
      else if (regWrStb)
      begin
         case (regAddr)
            cpi_pkg::ADDR_IRQ_CTRL: irqCtrl_q <= regWrData[2:0];
            cpi_pkg::ADDR_RATE:     rate_q    <= regWrData;
            cpi_pkg::ADDR_LV_CTRL:  low_voltage_irq_enable_q    <= regWrData[0];
            cpi_pkg::ADDR_AP_CTRL:  autonomous_periodic_irq_enable_q    <= regWrData[0];
            cpi_pkg::ADDR_CLK_CTRL: clkCtrl_q <= regWrData[3:0];
            cpi_pkg::ADDR_MASK:     mask_q    <= regWrData[4:0];
            default:                mask_q    <= mask_q;
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         flags_q    <= 5'h00;
         lock_q     <= 1'b0;
         lockSeen_q <= 1'b0;
         oscUp_q    <= 1'b0;
         lv_q       <= 1'b0;
         rcPrev_q   <= 1'b0;
         xoPrev_q   <= 1'b0;
      end
      else
      begin
         flags_q    <= flags_d;
         lock_q     <= pllLock;
         // lock qualifies up status; cleared when oscillator is switched off [R11]
         lockSeen_q <= clkCtrl_q[cpi_pkg::OSCEN_BIT] && (lockSeen_q || pllLock);
         oscUp_q    <= oscUp_d;
         lv_q       <= lowVoltage;
         rcPrev_q   <= internal_rc_clock;
         xoPrev_q   <= crystal_osc_clock;
      end
   end

   // outputs straight from flops; requests follow flag and enable [R14] [R8] [R4]
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         rdData_q <= 8'h00;
         irqReq_q <= 5'h00;
         irqOut_q <= 1'b0;
      end
      else
      begin
         rdData_q <= regRdStb ? rdMux : 8'h00;
         irqReq_q <= flags_d & enables;
         irqOut_q <= |(flags_d & mask_q);
      end
   end

   assign regRdData = rdData_q;
   assign irqReq    = irqReq_q;
   assign irqOut    = irqOut_q;

   //////////////////////////////////////////////////////////////////////////////////////////////
   // checks
   // requests compare against the flag as it now stands, not the next-value logic
   AST_REQ_FOLLOWS: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R14]
      irqReq == (flags_q & $past(enables)))
      else $error("request does not follow flag and enable");
   AST_IRQ_OUT: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R1]
      irqOut == |(flags_q & $past(mask_q)))
      else $error("combined request does not follow flag and mask");
   AST_TMO_REQ: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R4]
      irqReq[cpi_pkg::FLD_TIMEOUT]
      == (flags_q[cpi_pkg::FLD_TIMEOUT] && $past(irqCtrl_q[cpi_pkg::FLD_TIMEOUT])))
      else $error("timeout request does not follow flag and enable");
   AST_OSC_LOCK: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R11]
      $rose(oscUp_q) |-> lockSeen_q)
      else $error("up status set before lock");
   AST_OSC_STOP: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R13]
      (stopMode && !runInStop) |=> !oscUp_q)
      else $error("up status kept in full stop");
   AST_TMO_W1C: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R15]
      (wrFlags && regWrData[cpi_pkg::FLD_TIMEOUT] && !events[cpi_pkg::FLD_TIMEOUT])
      |=> !flags_q[cpi_pkg::FLD_TIMEOUT])
      else $error("write one did not clear timeout flag");
   AST_ZERO_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R15]
      (wrFlags && !regWrData[cpi_pkg::FLD_OSC] && flags_q[cpi_pkg::FLD_OSC])
      |=> flags_q[cpi_pkg::FLD_OSC])
      else $error("write zero cleared flag");
   AST_LOCK_W1C: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R9]
      (wrFlags && regWrData[cpi_pkg::FLD_LOCK] && !events[cpi_pkg::FLD_LOCK])
      |=> !flags_q[cpi_pkg::FLD_LOCK])
      else $error("write one did not clear lock flag");
   AST_LOCK_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R9]
      (!wrFlags && flags_q[cpi_pkg::FLD_LOCK]) |=> flags_q[cpi_pkg::FLD_LOCK])
      else $error("lock flag dropped without a clear");
   AST_RD_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !regRdStb |=> (regRdData == 8'h00))
      else $error("read data outside the read cycle");
   AST_LOCK_OFF: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R8]
      !irqCtrl_q[cpi_pkg::FLD_LOCK] |=> !irqReq[cpi_pkg::FLD_LOCK])
      else $error("lock request with enable clear");
   AST_LOCK_CHG: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R7]
      (pllLock != lock_q) |=> flags_q[cpi_pkg::FLD_LOCK])
      else $error("lock change did not set flag");
   AST_OSC_OFF: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R10]
      !clkCtrl_q[cpi_pkg::OSCEN_BIT] |=> !oscUp_q)
      else $error("up status set with oscillator off");
   AST_OSC_CHG: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R12]
      $changed(oscUp_q) |-> flags_q[cpi_pkg::FLD_OSC])
      else $error("up status change did not set flag");
   AST_TMO_SET: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R5]
      tmrBus.expire |=> flags_q[cpi_pkg::FLD_TIMEOUT])
      else $error("expiry did not set timeout flag");
   AST_HALT: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R3]
      (stopMode && !runInStop) |-> !tmrBus.tick)
      else $error("timer ticked in halted stop");
   AST_RESTART: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R6]
      wrRate |=> !tmrBus.expire)
      else $error("expiry right after rate write");
   AST_W1C: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R15]
      (wrFlags && regWrData[cpi_pkg::FLD_OSC] && !events[cpi_pkg::FLD_OSC])
      |=> !flags_q[cpi_pkg::FLD_OSC])
      else $error("write one did not clear flag");
   COV_TMO: cover property (@(posedge sys_clk) disable iff (!rst_b) tmrBus.expire);
   COV_LOCK: cover property (@(posedge sys_clk) disable iff (!rst_b) $rose(lock_q));
   COV_OSC: cover property (@(posedge sys_clk) disable iff (!rst_b) $rose(oscUp_q));
   COV_IRQ: cover property (@(posedge sys_clk) disable iff (!rst_b) $rose(irqOut));
endmodule // cpi_irq_sources

// ---- bench/cpi_clock_src_model.sv ----
// far-side model: free-running reference and crystal clocks seen by the timer
`timescale 1ns/1ps
module cpi_clock_src_model
#(
   parameter realtime RC_HALF  = 10.0,
   parameter realtime OSC_HALF = 15.0
)
(
   output logic internal_rc_clock,
   output logic crystal_osc_clock
);
   // odd start offsets keep both clocks out of phase with the bus clock
   initial
   begin
      internal_rc_clock = 1'b0;
      #3.1;
      forever #(RC_HALF) internal_rc_clock = ~internal_rc_clock;
   end
   initial
   begin
      crystal_osc_clock = 1'b0;
      #1.7;
      forever #(OSC_HALF) crystal_osc_clock = ~crystal_osc_clock;
   end
endmodule // cpi_clock_src_model

// ---- bench/clock_power_interrupt_sources_tb.sv ----
// self-checking bench for the clock and power interrupt sources
`timescale 1ns/1ps
module clock_power_interrupt_sources_tb;
   logic       sys_clk, rst_b, regWrStb, regRdStb, irqOut, rdDly;
   logic       pllLock, oscStable, stopMode, lowVoltage, apiEvent;
   logic       internal_rc_clock, crystal_osc_clock;
   logic [3:0] regAddr;
   logic [7:0] regWrData, regRdData;
   logic [4:0] irqReq, m;
   logic [7:0] r;
   logic [7:0] expQ[$];
   int         errors, checked, seed, cyc;
   ////////////////////////////////////////////////////////////////////////////
   cpi_irq_sources DUT (.sys_clk, .rst_b, .regAddr, .regWrData, .regWrStb, .regRdStb,
      .regRdData, .internal_rc_clock, .crystal_osc_clock, .pllLock, .oscStable,
      .stopMode, .lowVoltage, .apiEvent, .irqReq, .irqOut);
   cpi_clock_src_model model (.internal_rc_clock, .crystal_osc_clock);
   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge sys_clk);
      regWrStb <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask
   // the note goes on the queue now, the monitor matches it two cycles later
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      regAddr <= a;
      regRdStb <= 1'b1;
      expQ.push_back(e);
      @(posedge sys_clk);
      regRdStb <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask
   task automatic wait_req(input int lim);
      int n = 0;
      while (irqReq[0] !== 1'b1 && n < lim)
      begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= lim)
      begin
         chk("timeout request", 8'h00, 8'h01);
         end_sim();
      end
   endtask
   // tick phase against the bus clock blurs the figure by a few cycles
   task automatic gap(input int expc, input logic [3:0] a, input logic [7:0] d);
      int t = cyc;
      wr(a, d);
      wait_req(expc + 40);
      chk("timeout period", 8'((cyc - t > expc - 8) && (cyc - t < expc + 8)), 8'h01);
   endtask
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      rdDly <= regRdStb;
      if (rdDly === 1'b1)
         chk("read data", regRdData, expQ.pop_front());
   end
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {rst_b, regAddr, regWrData, regWrStb, regRdStb, pllLock, oscStable} = '0;
      {lowVoltage, apiEvent, errors, checked, cyc, rdDly} = '0;
      stopMode = 1'b1;
      seed = 52860;
      repeat (8) @(posedge sys_clk);
      rst_b <= 1'b1;
      wr(4'h8, 8'hff);
      for (int a = 0; a < 10; a++)
         rd(a[3:0], (a == 1) ? cpi_pkg::RATE_RESET : 8'h00);
      $display("reset values done");
      lowVoltage <= 1'b1;
      apiEvent <= 1'b1;
      @(posedge sys_clk);
      apiEvent <= 1'b0;
      wr(cpi_pkg::ADDR_LV_CTRL, 8'h01);
      wr(cpi_pkg::ADDR_AP_CTRL, 8'h01);
      chk("requests", {3'h0, irqReq}, 8'h18);
      for (int i = 0; i < 4; i++)
      begin
         m = 5'($random(seed));
         wr(cpi_pkg::ADDR_MASK, {3'h0, m});
         chk("combined request", {7'h0, irqOut}, {7'h0, |(m & 5'h18)});
      end
      wr(cpi_pkg::ADDR_FLAGS, 8'h08);
      rd(cpi_pkg::ADDR_FLAGS, 8'h10);
      wr(cpi_pkg::ADDR_FLAGS, 8'h1f);
      $display("masking done");
      wr(cpi_pkg::ADDR_IRQ_CTRL, 8'h02);
      pllLock <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk("lock request", {7'h0, irqReq[1]}, 8'h01);
      wr(cpi_pkg::ADDR_FLAGS, 8'h00);
      rd(cpi_pkg::ADDR_FLAGS, 8'h02);
      wr(cpi_pkg::ADDR_FLAGS, 8'h02);
      rd(cpi_pkg::ADDR_FLAGS, 8'h00);
      pllLock <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rd(cpi_pkg::ADDR_FLAGS, 8'h02);
      wr(cpi_pkg::ADDR_IRQ_CTRL, 8'h04);
      chk("lock suppressed", {7'h0, irqReq[1]}, 8'h00);
      wr(cpi_pkg::ADDR_FLAGS, 8'h1f);
      $display("lock done");
      // pseudo-stop with oscillator run keeps up status alive in stop; timer runs slowly
      wr(cpi_pkg::ADDR_CLK_CTRL, 8'h0f);
      oscStable <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rd(cpi_pkg::ADDR_STATUS, 8'h00);
      pllLock <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rd(cpi_pkg::ADDR_STATUS, 8'h03);
      rd(cpi_pkg::ADDR_FLAGS, 8'h06);
      chk("osc request", {3'h0, irqReq}, 8'h04);
      wr(cpi_pkg::ADDR_FLAGS, 8'h1f);
      wr(cpi_pkg::ADDR_CLK_CTRL, 8'h07);
      rd(cpi_pkg::ADDR_STATUS, 8'h02);
      rd(cpi_pkg::ADDR_FLAGS, 8'h04);
      $display("oscillator done");
      stopMode <= 1'b0;
      r = 8'($random(seed)) & 8'h03;
      wr(cpi_pkg::ADDR_CLK_CTRL, 8'h00);
      wr(cpi_pkg::ADDR_IRQ_CTRL, 8'h01);
      gap(64 * (r + 1), cpi_pkg::ADDR_RATE, r);
      gap(64 * (r + 1), cpi_pkg::ADDR_FLAGS, 8'h01);
      wr(cpi_pkg::ADDR_FLAGS, 8'h01);
      repeat (30) @(posedge sys_clk);
      gap(64 * (r + 1), cpi_pkg::ADDR_RATE, r);
      wr(cpi_pkg::ADDR_CLK_CTRL, 8'h01);
      wr(cpi_pkg::ADDR_FLAGS, 8'h01);
      gap(96 * (r + 1), cpi_pkg::ADDR_RATE, r);
      gap(96 * (r + 1), cpi_pkg::ADDR_FLAGS, 8'h01);
      stopMode <= 1'b1;
      wr(cpi_pkg::ADDR_FLAGS, 8'h01);
      repeat (500) @(posedge sys_clk);
      chk("halted in stop", {7'h0, irqReq[0]}, 8'h00);
      wr(cpi_pkg::ADDR_CLK_CTRL, 8'h07);
      gap(96 * (r + 1), cpi_pkg::ADDR_RATE, r);
      $display("timer done");
      end_sim();
   end
endmodule // clock_power_interrupt_sources_tb
